// file: bench/slce_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module slce_regs_chk
  import slce_pkg::*;
#(parameter int FULL_LANES = 8, parameter int FULL_CONVS = 8) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [9:0] addr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic link_up_in,
  input wire logic sync_n_in,
  input wire logic sysref_shift_in,
  input wire logic spll_lock_in,
  input wire logic cpll_lock_in,
  input wire logic [3:0] chan_on_out,
  input wire logic single_mode_out,
  input wire logic [3:0] lanes_out,
  input wire logic [3:0] convs_out,
  input wire logic tail_pad_out,
  input wire logic swap_cd_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Status read, and a realign pulse followed by it
  sequence st_rd; rd_in && addr_in == SLCE_STATUS_ADDR; endsequence
  sequence shift_rd; sysref_shift_in ##1 st_rd; endsequence
  // Exactly one pair running
  wire logic half = chan_on_out == 4'h3 || chan_on_out == 4'hc;
  a_live_bits: assert property (st_rd |=> rdata_out == {1'b0,
    $past(link_up_in), $past(sync_n_in), rdata_out[4:3],
    $past(spll_lock_in), 1'b0, $past(cpll_lock_in)}) else $error("live");
  a_realign_set: assert property (shift_rd |=> rdata_out[4])
    else $error("realign");
  a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("idle");
  a_single_off: assert property (single_mode_out |->
    chan_on_out == 4'h1) else $error("single");
  a_pair_map: assert property (!single_mode_out |->
    chan_on_out[0] == chan_on_out[1] && chan_on_out[2] == chan_on_out[3])
    else $error("pairs");
  a_swap_pos: assert property (swap_cd_out == (chan_on_out == 4'hc))
    else $error("swap");
  a_half_shape: assert property (half |->
    lanes_out == 4'((FULL_LANES + 1) / 2) &&
    convs_out == 4'(FULL_CONVS / 2)) else $error("half");
  a_tail_odd: assert property (half |-> tail_pad_out == FULL_LANES[0])
    else $error("tail");
  a_reset_full: assert property ($fell(reset_in) |-> chan_on_out == 4'hf
    && lanes_out == 4'(FULL_LANES)) else $error("reset");
endmodule
bind slce_regs slce_regs_chk #(.FULL_LANES(FULL_LANES),
  .FULL_CONVS(FULL_CONVS)) i_chk (.core_clk_in, .reset_in, .addr_in,
  .rd_in, .rdata_out, .link_up_in, .sync_n_in, .sysref_shift_in,
  .spll_lock_in, .cpll_lock_in, .chan_on_out, .single_mode_out,
  .lanes_out, .convs_out, .tail_pad_out, .swap_cd_out);
`default_nettype wire

// file: bench/test_slce_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_slce_regs;
  import slce_pkg::*;
  logic core_clk_in, reset_in, wr_in, rd_in, link_up_in, sync_n_in;
  logic sysref_shift_in, sysref_event_in, link_enable_in, spll_lock_in;
  logic cpll_lock_in, single_mode_out, tail_pad_out, swap_cd_out, irq_out;
  logic [9:0] addr_in;
  logic [7:0] wdata_in, rdata_out;
  logic [3:0] chan_on_out, lanes_out, convs_out;
  int fail_count = 0;
  int check_count = 0;
  // Channel table: written value, expected channel enables
  logic [11:0] tv [4] = '{12'h03f, 12'h013, 12'h02c, 12'h071};
  slce_regs i_slce_regs (.core_clk_in, .reset_in, .clk_en_in(1'b1),
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .link_up_in,
    .sync_n_in, .sysref_shift_in, .sysref_event_in, .link_enable_in,
    .spll_lock_in, .cpll_lock_in, .chan_on_out, .single_mode_out,
    .lanes_out, .convs_out, .tail_pad_out, .swap_cd_out, .irq_out);
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // Bus cycles leave one idle edge before the next strobe
  task automatic wr(logic [9:0] a, logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e, string n);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk(n, e, rdata_out);
    @(posedge core_clk_in);
  endtask
  task automatic sysref(logic s, logic e);
    {sysref_shift_in, sysref_event_in} <= {s, e};
    @(posedge core_clk_in);
    {sysref_shift_in, sysref_event_in} <= 2'b00;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk_in);
    fail_count++;
    complete_run;
  end
  initial begin
    reset_in = 1'b1;
    {wr_in, rd_in, sysref_shift_in, sysref_event_in, link_enable_in} = '0;
    {addr_in, wdata_in} = '0;
    {link_up_in, sync_n_in, spll_lock_in, cpll_lock_in} = 4'b1010;
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(SLCE_CHEN_ADDR, SLCE_CHEN_RESET, "chen");
    rd(SLCE_STATUS_ADDR, 8'h44, "status");
    {link_up_in, sync_n_in, spll_lock_in, cpll_lock_in} <= 4'b0101;
    wr(SLCE_STATUS_ADDR, 8'hff);
    rd(SLCE_STATUS_ADDR, 8'h21, "status");
    sysref(1'b1, 1'b0);
    rd(SLCE_STATUS_ADDR, 8'h31, "realign");
    wr(SLCE_STATUS_ADDR, 8'h00);
    rd(SLCE_STATUS_ADDR, 8'h31, "realign");
    wr(SLCE_STATUS_ADDR, 8'h10);
    rd(SLCE_STATUS_ADDR, 8'h21, "realign");
    link_enable_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sysref(1'b0, 1'b1);
    rd(SLCE_STATUS_ADDR, 8'h29, "multiframe_flag_a");
    wr(SLCE_STATUS_ADDR, 8'h08);
    sysref(1'b0, 1'b1);
    rd(SLCE_STATUS_ADDR, 8'h21, "multiframe_flag_a");
    rd(SLCE_IRQ_STAT_ADDR, 8'h07, "irq_stat");
    wr(SLCE_IRQ_STAT_ADDR, 8'h07);
    wr(SLCE_IRQ_MASK_ADDR, 8'h01);
    rd(SLCE_IRQ_MASK_ADDR, 8'h01, "irq_mask");
    sysref(1'b1, 1'b0);
    rd(SLCE_IRQ_STAT_ADDR, 8'h01, "irq_stat");
    chk("irq", 8'h01, {7'h0, irq_out});
    wr(SLCE_IRQ_MASK_ADDR, 8'h00);
    chk("irq", 8'h00, {7'h0, irq_out});
    wr(SLCE_IRQ_STAT_ADDR, 8'h01);
    rd(SLCE_IRQ_STAT_ADDR, 8'h00, "irq_stat");
    rd(10'h3ff, 8'h00, "unmapped");
    link_enable_in <= 1'b0;
    // Never both pairs off; single mode keeps only channel A on
    for (int k = 0; k < 4; k++) begin
      wr(SLCE_CHEN_ADDR, tv[k][11:4]);
      rd(SLCE_CHEN_ADDR, tv[k][11:4], "chen");
      chk("chan_on", {4'h0, tv[k][3:0]}, {4'h0, chan_on_out});
      chk("swap", {7'h0, k == 2}, {7'h0, swap_cd_out});
      chk("single", {7'h0, tv[k][6]}, {7'h0, single_mode_out});
      chk("tail", 8'h00, {7'h0, tail_pad_out});
      if (k == 1 || k == 2) chk("shape", 8'h44, {lanes_out, convs_out});
    end
    reset_in <= 1'b1;
    @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(SLCE_CHEN_ADDR, SLCE_CHEN_RESET, "chen");
    complete_run;
  end
endmodule
`default_nettype wire

// file: common/slce_pkg.sv
package slce_pkg;
  // Register offsets
  localparam logic [9:0] SLCE_STATUS_ADDR = 10'h208;
  localparam logic [9:0] SLCE_CHEN_ADDR = 10'h209;
  localparam logic [9:0] SLCE_IRQ_STAT_ADDR = 10'h20a;
  localparam logic [9:0] SLCE_IRQ_MASK_ADDR = 10'h20b;
  // Status bit positions
  localparam int SLCE_ST_LINK_UP = 6;
  localparam int SLCE_ST_SYNC = 5;
  localparam int SLCE_ST_REALIGN = 4;
  localparam int SLCE_ST_MULTIFRAME_FLAG_A = 3;
  localparam int SLCE_ST_SPLL = 2;
  localparam int SLCE_ST_CPLL = 0;
  // Channel enable bit positions
  localparam int SLCE_CH_SINGLE = 2;
  localparam int SLCE_CH_SECOND = 1;
  localparam int SLCE_CH_FIRST = 0;
  // Interrupt bit positions
  localparam int SLCE_IRQ_REALIGN = 0;
  localparam int SLCE_IRQ_MULTIFRAME_FLAG_A = 1;
  localparam int SLCE_IRQ_LOCKLOSS = 2;
  // Reset values
  localparam logic [7:0] SLCE_CHEN_RESET = 8'h03;
  localparam logic [7:0] SLCE_ZERO8 = 8'h00;

  // Derived link shape
  typedef struct packed {
    logic [3:0] chan_on;
    logic [3:0] lanes;
    logic [3:0] convs;
    logic tail_pad;
    logic swap_cd;
  } slce_shape_t;

  // Whole state of the bank
  typedef struct packed {
    logic [2:0] chen;
    logic realign;
    logic multiframe_flag_a;
    logic armed;
    logic link_en_d;
    logic spll_d;
    logic cpll_d;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
  } slce_state_t;
endpackage

// file: hw/slce_regs.sv
// Function
// - Link-up bit follows live link state
// - Sync bit reads zero while sync asserted
// - SYSREF phase shift sets sticky realign flag
// - First SYSREF after enable sets multiframe_flag_a flag
// - Writing one clears flag, zero keeps
// - Serializer PLL lock bit follows lock
// - Converter PLL lock bit follows lock
// - Single-channel mode disables channels B, C, D
// - Second-pair bit enables channels C, D
// - First-pair bit enables channels A, B
// - Channel enable register resets to 0x03
// - One pair off halves converters, lanes ceil-halved
// - Odd full lane count adds tail bits when the shape is halved
// - First pair off moves C, D to A, B
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module slce_regs
  import slce_pkg::*;
#(
  parameter int FULL_LANES = 8,
  parameter int FULL_CONVS = 8
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic link_up_in,
  input wire logic sync_n_in,
  input wire logic sysref_shift_in,
  input wire logic sysref_event_in,
  input wire logic link_enable_in,
  input wire logic spll_lock_in,
  input wire logic cpll_lock_in,
  output logic [3:0] chan_on_out,
  output logic single_mode_out,
  output logic [3:0] lanes_out,
  output logic [3:0] convs_out,
  output logic tail_pad_out,
  output logic swap_cd_out,
  output logic irq_out
);

  // Lane count must fit the four-bit lane output
  if (FULL_LANES < 1 || FULL_LANES > 15) begin : g_bad_lanes
    $error("slce_regs: unsupported lane count");
  end

  // Converter count must fit the four-bit converter output
  if (FULL_CONVS < 2 || FULL_CONVS > 15) begin : g_bad_convs
    $error("slce_regs: unsupported converter count");
  end

  // Halving the converter count needs an even full count
  if ((FULL_CONVS % 2) != 0) begin : g_odd_convs
    $error("slce_regs: converter count must be even");
  end

  // Full and halved link shapes, fixed at elaboration
  localparam logic [3:0] L_FULL = 4'(FULL_LANES);
  localparam logic [3:0] L_HALF = 4'((FULL_LANES + 1) / 2);
  localparam logic [3:0] M_FULL = 4'(FULL_CONVS);
  localparam logic [3:0] M_HALF = 4'(FULL_CONVS / 2);
  localparam logic L_ODD = (FULL_LANES % 2) != 0;

  // Registered state and its next value
  slce_state_t st_ff;
  slce_state_t nxt_st;

  // Derived link shape
  slce_shape_t shape;

  // Live status word as software sees it
  logic [7:0] status_rd;

  // Read multiplexer result
  logic [7:0] rd_sel;

  // Interrupt events of this cycle
  logic [2:0] irq_ev;

  // Register selects
  logic sel_stat;
  logic sel_chen;
  logic sel_irq;
  logic sel_mask;

  // Write strobes per register
  logic wr_stat;
  logic wr_chen;
  logic wr_irq;
  logic wr_mask;

  // Single-cycle events
  logic link_en_rise;
  logic spll_lost;
  logic cpll_lost;
  logic align_hit;

  // Address decode, one compare per register
  always_comb begin
    sel_stat = 1'b0;
    sel_chen = 1'b0;
    sel_irq = 1'b0;
    sel_mask = 1'b0;
    if (addr_in == SLCE_STATUS_ADDR) begin
      sel_stat = 1'b1;
    end else if (addr_in == SLCE_CHEN_ADDR) begin
      sel_chen = 1'b1;
    end else if (addr_in == SLCE_IRQ_STAT_ADDR) begin
      sel_irq = 1'b1;
    end else if (addr_in == SLCE_IRQ_MASK_ADDR) begin
      sel_mask = 1'b1;
    end
  end

  // Write strobes; unmapped writes fall through
  assign wr_stat = wr_in && sel_stat;
  assign wr_chen = wr_in && sel_chen;
  assign wr_irq = wr_in && sel_irq;
  assign wr_mask = wr_in && sel_mask;

  // Live status view, flags from state
  always_comb begin
    status_rd = SLCE_ZERO8;
    status_rd[SLCE_ST_LINK_UP] = link_up_in;
    status_rd[SLCE_ST_SYNC] = sync_n_in;
    status_rd[SLCE_ST_REALIGN] = st_ff.realign;
    status_rd[SLCE_ST_MULTIFRAME_FLAG_A] = st_ff.multiframe_flag_a;
    status_rd[SLCE_ST_SPLL] = spll_lock_in;
    status_rd[SLCE_ST_CPLL] = cpll_lock_in;
  end

  // Edge and event detection
  always_comb begin
    link_en_rise = link_enable_in && !st_ff.link_en_d;
    spll_lost = st_ff.spll_d && !spll_lock_in;
    cpll_lost = st_ff.cpll_d && !cpll_lock_in;
    // Only the first event of an enable window aligns
    align_hit = sysref_event_in && st_ff.armed && link_enable_in;
  end

  // Interrupt events, one bit per cause
  always_comb begin
    irq_ev = 3'h0;
    irq_ev[SLCE_IRQ_REALIGN] = sysref_shift_in;
    irq_ev[SLCE_IRQ_MULTIFRAME_FLAG_A] = align_hit;
    irq_ev[SLCE_IRQ_LOCKLOSS] = spll_lost || cpll_lost;
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_sel = SLCE_ZERO8;
    if (sel_stat) begin
      rd_sel = status_rd;
    end else if (sel_chen) begin
      rd_sel = {5'h00, st_ff.chen};
    end else if (sel_irq) begin
      rd_sel = {5'h00, st_ff.irq_stat};
    end else if (sel_mask) begin
      rd_sel = {5'h00, st_ff.irq_mask};
    end else begin
      rd_sel = SLCE_ZERO8;
    end
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;

    // Multiframe_flag_a arms again on each rise of link enable
    nxt_st.link_en_d = link_enable_in;
    if (link_en_rise) begin
      nxt_st.armed = 1'b1;
    end
    if (!link_enable_in) begin
      nxt_st.armed = 1'b0;
    end

    // Write-one clears, set wins
    if (wr_stat && wdata_in[SLCE_ST_REALIGN]) begin
      nxt_st.realign = 1'b0;
    end
    if (wr_stat && wdata_in[SLCE_ST_MULTIFRAME_FLAG_A]) begin
      nxt_st.multiframe_flag_a = 1'b0;
    end

    // Phase shift by the reference pulse
    if (sysref_shift_in) begin
      nxt_st.realign = 1'b1;
    end

    // First reference event after enabling
    if (align_hit) begin
      nxt_st.multiframe_flag_a = 1'b1;
      nxt_st.armed = 1'b0;
    end

    // Lock history for the loss events
    nxt_st.spll_d = spll_lock_in;
    nxt_st.cpll_d = cpll_lock_in;

    // Live status bits have no storage to write
    if (wr_stat) begin
      nxt_st.spll_d = spll_lock_in;
    end

    // Channel enable register
    if (wr_chen) begin
      nxt_st.chen = wdata_in[2:0];
    end

    // Interrupt mask register
    if (wr_mask) begin
      nxt_st.irq_mask = wdata_in[2:0];
    end

    // Interrupt status: write-one clears, set wins
    if (wr_irq) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~wdata_in[2:0];
    end
    nxt_st.irq_stat = nxt_st.irq_stat | irq_ev;

    // Read data stands one cycle after the strobe
    nxt_st.rdata = SLCE_ZERO8;
    if (rd_in) begin
      nxt_st.rdata = rd_sel;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_ff <= '0;
      st_ff.chen <= SLCE_CHEN_RESET[2:0];
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  // Per-channel enables from the pair bits
  always_comb begin
    shape.chan_on = 4'h0;
    shape.chan_on[0] = st_ff.chen[SLCE_CH_FIRST];
    shape.chan_on[1] = st_ff.chen[SLCE_CH_FIRST] &&
                       !st_ff.chen[SLCE_CH_SINGLE];
    shape.chan_on[2] = st_ff.chen[SLCE_CH_SECOND] &&
                       !st_ff.chen[SLCE_CH_SINGLE];
    shape.chan_on[3] = shape.chan_on[2];

    // Full shape unless a pair is off
    shape.lanes = L_FULL;
    shape.convs = M_FULL;
    shape.tail_pad = 1'b0;
    if (!st_ff.chen[SLCE_CH_FIRST] || !st_ff.chen[SLCE_CH_SECOND]) begin
      shape.lanes = L_HALF;
      shape.convs = M_HALF;
      shape.tail_pad = L_ODD;
    end

    // Second pair moves into the first pair's slots
    shape.swap_cd = !st_ff.chen[SLCE_CH_FIRST];
  end

  // Channel outputs
  assign chan_on_out = shape.chan_on;
  assign single_mode_out = st_ff.chen[SLCE_CH_SINGLE];

  // Link shape outputs
  assign lanes_out = shape.lanes;
  assign convs_out = shape.convs;
  assign tail_pad_out = shape.tail_pad;
  assign swap_cd_out = shape.swap_cd;

  // Register read data
  assign rdata_out = st_ff.rdata;

  // Level interrupt from unmasked sticky causes
  assign irq_out = |(st_ff.irq_stat & st_ff.irq_mask);

  // Notes for integrators:
  // Status read takes the live inputs of the strobe cycle.
  // Sticky flags and the channel register hold while the
  // clock enable is low, and so does pending read data.
  // A reference event in the same cycle as the enable rise
  // does not align; the window opens one cycle later.
  // A write to the channel register takes effect at once;
  // the link must be stopped by software beforehand.
  // Clearing both pairs is not guarded; channel outputs
  // then all read low and the shape stays halved.
  // Single mode with the first pair off leaves every
  // channel output low; software must avoid it.
  // Interrupt status clears and new events in one cycle
  // keep the event, so no cause is lost.
  // Lock loss is taken from a falling lock level; a PLL
  // that stays unlocked raises it once only.
  // Bits above the used ones read zero everywhere.
  // The shape outputs are combinational from the channel
  // register and change in the cycle after a write.
  // Read data returns to zero the cycle after it stands,
  // so a bus sampling late sees zero, not stale data.
  // Mask and status share one bit layout.
  // The elaboration checks above refuse shapes that the
  // four-bit counts cannot carry.
endmodule
`default_nettype wire
